// ==== src/dacipr_pkg.sv ====
// shared constants for the input port router
package dacipr_pkg;
   localparam int WORD_W = 16;
   localparam int PORTB_LOW_W = 14;
   localparam int Q_MSB_POS = 15;
   localparam int Q_BIT14_POS = 14;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   // double-rate clock toggles every core edge: one toggle per channel word
   localparam int DCLK_HALF_PERIOD_CYCLES = 1;
endpackage

// ==== src/dac_input_port_router.sv ====
// input data port steering for the interpolating dac front end
//----------------------------------------------------------------
// Behaviour
// - two-port mode: every port A word goes to the I channel
// - single-port mode: port A words split into I and Q by select level
// - single-port: select differing from polarity sends word to I
// - single-port: select equal to polarity sends word to Q
// - two-port: select pin is latched as Q word bit 15
// - two-port: shared clock pin is input, latched as Q word bit 14
// - single-port: shared pin drives clock toggling every core edge, at half the word rate
//----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module dac_input_port_router
   import dacipr_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic single_port_sel,
   input wire logic iq_select_polarity,
   input wire logic [dacipr_pkg::WORD_W-1:0] port_a_data,
   input wire logic [dacipr_pkg::PORTB_LOW_W-1:0] port_b_data_low,
   input wire logic select_or_q_msb_pin,
   input wire logic double_rate_clk_or_q_bit14_pin_in,
   output logic double_rate_clk_or_q_bit14_pin_out,
   output logic double_rate_clk_or_q_bit14_pin_oe,
   output logic [dacipr_pkg::WORD_W-1:0] iChannelData,
   output logic iChannelValid,
   output logic [dacipr_pkg::WORD_W-1:0] qChannelData,
   output logic qChannelValid
);
   import dacipr_pkg::*;

   //----------------------------------------------------------------
   // reset release
   //----------------------------------------------------------------
   logic rstSync1;
   logic rstSync2;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstSync1 <= 1'b0;
         rstSync2 <= 1'b0;
      end else begin
         rstSync1 <= 1'b1;
         rstSync2 <= rstSync1;
      end
   end
   wire logic rst_n = rstSync2;

   //----------------------------------------------------------------
   // state
   //----------------------------------------------------------------
   typedef struct packed {
      logic [WORD_W-1:0] iData;
      logic iValid;
      logic [WORD_W-1:0] qData;
      logic qValid;
      logic clkOut;
      logic clkOe;
   } dacipr_state_s;

   dacipr_state_s st;
   dacipr_state_s next_st;

   //----------------------------------------------------------------
   // next state
   //----------------------------------------------------------------
   // data words hold between valid pulses so a slow consumer can
   // still read the last word; valids are single-cycle strobes
   always_comb begin
      next_st = st;
      next_st.iValid = 1'b0;
      next_st.qValid = 1'b0;
      // pin direction follows mode; output only in single-port mode
      next_st.clkOe = single_port_sel;
      // clock parked low in two-port mode so a later switch starts clean
      next_st.clkOut = single_port_sel ? ~st.clkOut : 1'b0;
      if (!single_port_sel) begin
         next_st.iData = port_a_data;
         next_st.iValid = 1'b1;
         // shared pins are plain inputs here and fill the two top q bits
         next_st.qData = {select_or_q_msb_pin,
                          double_rate_clk_or_q_bit14_pin_in,
                          port_b_data_low};
         next_st.qValid = 1'b1;
      end else if (select_or_q_msb_pin != iq_select_polarity) begin
         next_st.iData = port_a_data;
         next_st.iValid = 1'b1;
      end else begin
         next_st.qData = port_a_data;
         next_st.qValid = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   //----------------------------------------------------------------
   // outputs
   //----------------------------------------------------------------
   // every output is a bare state bit, no logic after the flops
   assign iChannelData = st.iData;
   assign iChannelValid = st.iValid;
   assign qChannelData = st.qData;
   assign qChannelValid = st.qValid;
   assign double_rate_clk_or_q_bit14_pin_out = st.clkOut;
   assign double_rate_clk_or_q_bit14_pin_oe = st.clkOe;

   //----------------------------------------------------------------
   // checks
   //----------------------------------------------------------------
   a_two_port_i: assert property (@(posedge core_clk) disable iff (!rst_n)
      !single_port_sel |=> iChannelValid && iChannelData == $past(port_a_data))
      else $error("two-port word not routed to I");
   a_sp_split: assert property (@(posedge core_clk) disable iff (!rst_n)
      single_port_sel |=> iChannelValid != qChannelValid)
      else $error("single-port word not sent to exactly one channel");
   a_sp_to_i: assert property (@(posedge core_clk) disable iff (!rst_n)
      single_port_sel && select_or_q_msb_pin != iq_select_polarity
      |=> iChannelValid && iChannelData == $past(port_a_data))
      else $error("word should go to I");
   a_sp_to_q: assert property (@(posedge core_clk) disable iff (!rst_n)
      single_port_sel && select_or_q_msb_pin == iq_select_polarity
      |=> qChannelValid && qChannelData == $past(port_a_data))
      else $error("word should go to Q");
   a_q_msb: assert property (@(posedge core_clk) disable iff (!rst_n)
      !single_port_sel |=> qChannelData[Q_MSB_POS] == $past(select_or_q_msb_pin))
      else $error("Q msb not from select pin");
   a_q_bit14: assert property (@(posedge core_clk) disable iff (!rst_n)
      !single_port_sel |=> !double_rate_clk_or_q_bit14_pin_oe
      && qChannelData[Q_BIT14_POS] == $past(double_rate_clk_or_q_bit14_pin_in))
      else $error("Q bit 14 wrong or pin driven");
   a_dclk_toggle: assert property (@(posedge core_clk) disable iff (!rst_n)
      single_port_sel ##1 single_port_sel |=> double_rate_clk_or_q_bit14_pin_oe
      && double_rate_clk_or_q_bit14_pin_out != $past(double_rate_clk_or_q_bit14_pin_out))
      else $error("double-rate clock not toggling");
   a_q_low: assert property (@(posedge core_clk) disable iff (!rst_n)
      !single_port_sel |=> qChannelValid && qChannelData[PORTB_LOW_W-1:0] == $past(port_b_data_low))
      else $error("port B low bits not captured");

   //----------------------------------------------------------------
   // further checks on mode handling and reset
   //----------------------------------------------------------------
   // first edge after release must still show the reset image
   a_release_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(rst_n) |-> !iChannelValid && !qChannelValid && !double_rate_clk_or_q_bit14_pin_oe)
      else $error("outputs active at first edge after reset");
   a_two_port_q: assert property (@(posedge core_clk) disable iff (!rst_n)
      !single_port_sel |=> qChannelValid && iChannelValid)
      else $error("two-port sample missing a channel strobe");
   a_two_port_pin: assert property (@(posedge core_clk) disable iff (!rst_n)
      !single_port_sel |=> !double_rate_clk_or_q_bit14_pin_out)
      else $error("shared clock pin not parked in two-port mode");
   a_sp_pin_oe: assert property (@(posedge core_clk) disable iff (!rst_n)
      single_port_sel |=> double_rate_clk_or_q_bit14_pin_oe)
      else $error("shared pin not driven in single-port mode");
   a_sp_i_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      single_port_sel && select_or_q_msb_pin == iq_select_polarity
      |=> !iChannelValid && $stable(iChannelData))
      else $error("I channel disturbed by a Q word");
   a_sp_q_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      single_port_sel && select_or_q_msb_pin != iq_select_polarity
      |=> !qChannelValid && $stable(qChannelData))
      else $error("Q channel disturbed by an I word");
   a_every_word: assert property (@(posedge core_clk) disable iff (!rst_n)
      rst_n |=> iChannelValid || qChannelValid)
      else $error("sampled word dropped");

   // per-bit view of the port B capture, so a single stuck bit is named
   for (genvar b = 0; b < PORTB_LOW_W; b++) begin : g_portb_bit
      a_portb_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
         !single_port_sel |=> qChannelData[b] == $past(port_b_data_low[b]))
         else $error("port B bit not captured");
   end
endmodule
`default_nettype wire

// ==== tb/dacipr_host.sv ====
// host model of the shared clock/bit14 pin
`timescale 1ns/1ps
`default_nettype none
module dacipr_host (
   input wire logic pinOe,
   input wire logic pinOut,
   input wire logic hostBit,
   output logic pinLevel
);
   // host lets go while the device drives the clock
   assign pinLevel = pinOe ? pinOut : hostBit;
endmodule
`default_nettype wire

// ==== tb/test_dac_input_port_router.sv ====
// self-checking bench for the input port router
`timescale 1ns/1ps
`default_nettype none
module test_dac_input_port_router;
   logic core_clk = 0, arst_n = 0, single_port_sel = 0, iq_select_polarity = 0, sel = 0, hostBit = 0, armed = 0;
   logic [15:0] port_a_data = 16'h0000;
   logic [13:0] port_b_data_low = 14'h0000;
   logic pinLevel, pinOut, pinOe, iChannelValid, qChannelValid, lastOut, lastOe;
   logic [15:0] iChannelData, qChannelData;
   logic [33:0] q[$];
   logic [33:0] e;
   int miscompares = 0, checks = 0, cycles = 0;
   initial forever #2.5 core_clk = ~core_clk;
   dacipr_host i_host (.pinOe(pinOe), .pinOut(pinOut), .hostBit(hostBit), .pinLevel(pinLevel));
   dac_input_port_router i_dut (.core_clk(core_clk), .arst_n(arst_n), .single_port_sel(single_port_sel),
      .iq_select_polarity(iq_select_polarity), .port_a_data(port_a_data), .port_b_data_low(port_b_data_low),
      .select_or_q_msb_pin(sel), .double_rate_clk_or_q_bit14_pin_in(pinLevel),
      .double_rate_clk_or_q_bit14_pin_out(pinOut), .double_rate_clk_or_q_bit14_pin_oe(pinOe),
      .iChannelData(iChannelData), .iChannelValid(iChannelValid), .qChannelData(qChannelData),
      .qChannelValid(qChannelValid));
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s exp %h got %h", name, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // note what each sampling edge must produce one edge later
   always @(posedge core_clk) if (armed) begin
      if (!single_port_sel) q.push_back({2'b11, port_a_data, sel, pinLevel, port_b_data_low});
      else if (sel != iq_select_polarity) q.push_back({2'b10, port_a_data, 16'h0000});
      else q.push_back({2'b01, 16'h0000, port_a_data});
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles > 3000) begin
         miscompares++;
         report_and_stop();
      end
      if (pinOe === 1'b1 && lastOe === 1'b1) chk("pin_clock", {15'h0000, ~lastOut}, {15'h0000, pinOut});
      if (armed && q.size() > 0 && q[0][33:32] == 2'b11) chk("pin_oe", 16'h0000, {15'h0000, pinOe});
      lastOut = pinOut;
      lastOe = pinOe;
      if ((iChannelValid | qChannelValid) === 1'b1 && (armed || q.size() > 0)) begin
         e = q.size() > 0 ? q.pop_front() : 34'h000000000;
         chk("valids", {14'h0000, e[33:32]}, {14'h0000, iChannelValid, qChannelValid});
         if (e[33]) chk("i_data", e[31:16], iChannelData);
         if (e[32]) chk("q_data", e[15:0], qChannelData);
      end
   end
   initial begin
      void'($urandom(32'hbd5a));
      repeat (20) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("reset_valids", 16'h0000, {14'h0000, iChannelValid, qChannelValid});
      armed <= 1'b1;
      // mode order 00, 10, 11, 01 crosses both switch directions
      for (int i = 0; i < 400; i++) begin
         {single_port_sel, iq_select_polarity} <= 2'(8'h78 >> (2 * (i / 100)));
         sel <= 1'($urandom);
         hostBit <= 1'($urandom);
         port_a_data <= 16'($urandom);
         port_b_data_low <= 14'($urandom);
         @(posedge core_clk);
      end
      armed <= 1'b0;
      repeat (3) @(posedge core_clk);
      report_and_stop();
   end
endmodule
`default_nettype wire
